/* File: serial_eeprom_fifo.sv */
// Parameterised valid/ready FIFO carrying words toward the storage array.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("FIFO depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic [PW:0]      next_wr_ptr;
    logic [PW:0]      next_rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    always_comb begin
        full         = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
        empty        = (wr_ptr == rd_ptr);
        in_ready_out = !full;
        out_valid_out = !empty;
        out_data_out = mem[rd_ptr[PW-1:0]];
        push         = in_valid_in && !full;
        pop          = out_ready_in && !empty;
        next_wr_ptr  = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr  = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage needs no reset; only written entries are ever read
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= in_data_in;
        end
    end

    a_no_overflow: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        full |=> (wr_ptr == $past(wr_ptr)))
        else $error("FIFO pointer moved while full");
endmodule : serial_eeprom_fifo

`default_nettype wire

/* File: serial_eeprom_pkg.sv */
// Types shared by the serial memory port modules.
// Assumes the constants header sits in the same folder.
`default_nettype none
`include "serial_eeprom_regs.svh"

package serial_eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HUNT,
        ST_INSTR,
        ST_DATA,
        ST_READ,
        ST_ARMED,
        ST_PROG
    } port_state_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ERASE,
        OP_WRITE,
        OP_ERASE_ALL,
        OP_WRITE_ALL
    } prog_op_e;
endpackage : serial_eeprom_pkg

`default_nettype wire

/* File: serial_eeprom_port.sv */
// Device side of a three-wire serial memory: 16 words of 16 bits.
// Assumes select, serial clock, data and bulk enable come from pins outside the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_regs.svh"

module serial_eeprom_port
    import serial_eeprom_pkg::*;
#(
    parameter int WORDS     = `SE_WORDS,
    parameter int DATA_BITS = `SE_DATA_BITS
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    // Serial link pins
    input  wire logic chip_select_in,
    input  wire logic serial_clock_in,
    input  wire logic serial_in_in,
    output logic      serial_out_out,
    output logic      serial_out_oe_out,
    // Bulk programming gate, pulled high at the pad
    input  wire logic bulk_program_enable_in,
    // Status
    output logic      program_voltage_out,
    output logic      program_enabled_out
);
    localparam int FW = `SE_ADDR_BITS + 1 + DATA_BITS - 1;

    initial begin
        if (WORDS != `SE_WORDS || DATA_BITS != `SE_DATA_BITS) begin
            $error("Instruction format fixes 16 words of 16 bits");
        end
    end

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic       sclk_prev;
    logic       cs_prev;
    logic       cs;
    logic       din;
    logic       bulk_ok;
    logic       sclk_rise;
    logic       cs_fall;

    // Bulk bit resets high to match the pad pull-up
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            sync_a    <= 4'h8;
            sync_b    <= 4'h8;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b0;
        end else begin
            sync_a    <= {bulk_program_enable_in, serial_in_in, serial_clock_in, chip_select_in};
            sync_b    <= sync_a;
            sclk_prev <= sync_b[1];
            cs_prev   <= sync_b[0];
        end
    end

    always_comb begin
        cs        = sync_b[0];
        din       = sync_b[2];
        bulk_ok   = sync_b[3];
        sclk_rise = sync_b[1] && !sclk_prev;
        cs_fall   = cs_prev && !cs;
    end

    // ****************************************
    // Instruction state machine
    // ****************************************
    port_state_e          state;
    port_state_e          next_state;
    logic [7:0]           instr;
    logic [7:0]           next_instr;
    logic [4:0]           cnt;
    logic [4:0]           next_cnt;
    logic [DATA_BITS-1:0] shreg;
    logic [DATA_BITS-1:0] next_shreg;
    logic                 prog_en;
    logic                 next_prog_en;
    prog_op_e             op;
    prog_op_e             next_op;
    logic                 dout;
    logic                 next_dout;
    logic                 doe;
    logic                 next_doe;
    logic                 hv;
    logic                 next_hv;
    logic                 wr_req;
    logic [FW:0]          wr_word;
    logic                 fifo_ready;
    logic                 fifo_valid;
    logic [FW:0]          fifo_word;
    logic [DATA_BITS-1:0] array [WORDS];

    always_comb begin
        next_state   = state;
        next_instr   = instr;
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_prog_en = prog_en;
        next_op      = op;
        next_dout    = dout;
        next_doe     = 1'b0;
        next_hv      = 1'b0;
        wr_req       = 1'b0;
        wr_word      = '0;
        if (!cs && state != ST_ARMED && state != ST_PROG) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cs) begin
                        next_state = ST_HUNT;
                    end
                end
                ST_HUNT: begin
                    if (sclk_rise && din) begin
                        next_state = ST_INSTR;
                        next_cnt   = 5'd0;
                    end
                end
                ST_INSTR: begin
                    if (sclk_rise) begin
                        next_instr = {instr[6:0], din};
                        next_cnt   = cnt + 5'd1;
                        if (cnt == 5'd7) begin
                            next_cnt = 5'd0;
                            next_op  = OP_NONE;
                            // Decode from the seven held bits plus the bit now arriving
                            if (instr[6:5] == `SE_CLS_READ) begin
                                next_shreg = array[{instr[2:0], din}];
                                next_state = ST_READ;
                            end else if (instr[6:5] == `SE_CLS_ERASE) begin
                                next_op    = OP_ERASE;
                                next_state = ST_ARMED;
                            end else if (instr[6:5] == `SE_CLS_WRITE) begin
                                next_op    = OP_WRITE;
                                next_state = ST_DATA;
                            end else if (instr[6:3] == `SE_OPC_ENABLE) begin
                                next_prog_en = 1'b1;
                                next_state   = ST_HUNT;
                            end else if (instr[6:3] == `SE_OPC_DISABLE) begin
                                next_prog_en = 1'b0;
                                next_state   = ST_HUNT;
                            end else if (instr[6:3] == `SE_OPC_ERASE_ALL) begin
                                next_op    = OP_ERASE_ALL;
                                next_state = ST_ARMED;
                            end else begin
                                next_op    = OP_WRITE_ALL;
                                next_state = ST_DATA;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_rise) begin
                        next_shreg = {shreg[DATA_BITS-2:0], din};
                        next_cnt   = cnt + 5'd1;
                        if (cnt == 5'(DATA_BITS - 1)) begin
                            next_state = ST_ARMED;
                        end
                    end
                end
                ST_READ: begin
                    next_doe = 1'b1;
                    if (sclk_rise) begin
                        next_cnt = cnt + 5'd1;
                        if (cnt == 5'd0) begin
                            next_dout = 1'b0;
                        end else if (cnt <= 5'(DATA_BITS)) begin
                            next_dout  = shreg[DATA_BITS-1];
                            next_shreg = {shreg[DATA_BITS-2:0], 1'b0};
                        end else begin
                            next_doe   = 1'b0;
                            next_state = ST_HUNT;
                        end
                    end
                end
                ST_ARMED: begin
                    if (cs_fall) begin
                        if (prog_en && fifo_ready &&
                            (bulk_ok || (op != OP_ERASE_ALL && op != OP_WRITE_ALL))) begin
                            next_state = ST_PROG;
                            next_hv    = 1'b1;
                            wr_req     = 1'b1;
                            wr_word    = {op == OP_ERASE_ALL || op == OP_WRITE_ALL,
                                          instr[`SE_ADDR_MSB:`SE_ADDR_LSB],
                                          (op == OP_ERASE || op == OP_ERASE_ALL) ?
                                          `SE_WORD_ERASED : shreg};
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end else if (!cs) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_PROG: begin
                    next_hv = !cs;
                    if (cs) begin
                        next_state = ST_HUNT;
                    end
                end
            endcase
        end
        if (!next_doe) begin
            next_dout = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state   <= ST_IDLE;
            instr   <= 8'h00;
            cnt     <= 5'h00;
            shreg   <= 16'h0000;
            prog_en <= 1'b0;
            op      <= OP_NONE;
            dout    <= 1'b0;
            doe     <= 1'b0;
            hv      <= 1'b0;
        end else begin
            state   <= next_state;
            instr   <= next_instr;
            cnt     <= next_cnt;
            shreg   <= next_shreg;
            prog_en <= next_prog_en;
            op      <= next_op;
            dout    <= next_dout;
            doe     <= next_doe;
            hv      <= next_hv;
        end
    end

    // ****************************************
    // Array update through the FIFO
    // ****************************************
    serial_eeprom_fifo #(
        .WIDTH (FW + 1),
        .DEPTH (`SE_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rstn_in       (rstn_in),
        .in_valid_in   (wr_req),
        .in_data_in    (wr_word),
        .in_ready_out  (fifo_ready),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_word),
        .out_ready_in  (1'b1)
    );

    // Array keeps contents across reset, as nonvolatile storage does
    generate
        for (genvar w = 0; w < WORDS; w++) begin : g_word
            always_ff @(posedge core_clk_in) begin
                if (fifo_valid && (fifo_word[FW] ||
                    fifo_word[FW-1 -: `SE_ADDR_BITS] == 4'(w))) begin
                    array[w] <= fifo_word[DATA_BITS-1:0];
                end
            end
        end
    endgenerate

    always_comb begin
        serial_out_out      = dout;
        serial_out_oe_out   = doe;
        program_voltage_out = hv;
        program_enabled_out = prog_en;
    end

    a_oe_only_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        serial_out_oe_out |-> $past(state) == ST_READ)
        else $error("Output driven outside a read");
    a_hv_only_prog: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        program_voltage_out |-> $past(state) inside {ST_ARMED, ST_PROG})
        else $error("Programming voltage outside programming");
    a_no_prog_disabled: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        wr_req |-> prog_en)
        else $error("Programming started while disabled");
    a_bulk_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (wr_req && wr_word[FW]) |-> bulk_ok)
        else $error("Bulk command executed with gate low");
    a_dummy_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state == ST_READ && sclk_rise && cnt == 5'd0) |=> !serial_out_out)
        else $error("Dummy bit not zero");
    a_out_on_rise: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (serial_out_oe_out && $past(serial_out_oe_out) && $changed(serial_out_out))
        |-> $past(sclk_rise))
        else $error("Output changed without clock rise");
    a_enable_sticky: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ($fell(prog_en)) |-> $past(state) == ST_INSTR)
        else $error("Enable lost without a disable instruction");
    a_erase_ones: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (wr_req && (op == OP_ERASE || op == OP_ERASE_ALL)) |-> wr_word[DATA_BITS-1:0] == 16'hFFFF)
        else $error("Erase data not all ones");
endmodule : serial_eeprom_port

`default_nettype wire

/* File: serial_eeprom_port_tb.sv */
// Self-checking bench for the serial memory port, driven through the host model.
// Assumes the constants header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_regs.svh"

module serial_eeprom_port_tb;
    logic core_clk_in;
    logic rstn_in;
    logic bulk_program_enable_in;
    wire  chip_select;
    wire  serial_clock;
    wire  host_data;
    wire  serial_out;
    wire  serial_out_oe;
    wire  program_voltage;
    wire  program_enabled;
    int   n_errors;
    int   check_count;

    serial_eeprom_port dut (
        .core_clk_in            (core_clk_in),
        .rstn_in                (rstn_in),
        .chip_select_in         (chip_select),
        .serial_clock_in        (serial_clock),
        .serial_in_in           (host_data),
        .serial_out_out         (serial_out),
        .serial_out_oe_out      (serial_out_oe),
        .bulk_program_enable_in (bulk_program_enable_in),
        .program_voltage_out    (program_voltage),
        .program_enabled_out    (program_enabled)
    );

    serial_host_model host (
        .core_clk_in      (core_clk_in),
        .chip_select_out  (chip_select),
        .serial_clock_out (serial_clock),
        .host_data_out    (host_data),
        .serial_out_in    (serial_out),
        .serial_out_oe_in (serial_out_oe)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        check_count++;
        if (seen !== expected) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, expected, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic set_bulk(input logic level);
        @(posedge core_clk_in);
        bulk_program_enable_in <= level;
    endtask : set_bulk

    task automatic program_op(input logic [8:0] instr, input logic [15:0] data, input int n_data,
                              input logic pv_exp);
        host.send_frame(instr, data, n_data, 0);
        check("oe outside read", 32'(host.oe_count), 32'h0);
        host.release_select(20);
        check("program voltage", 32'(program_voltage), 32'(pv_exp));
        host.release_select(130);
    endtask : program_op

    task automatic read_word(input logic [3:0] addr, input logic [1:0] low, input logic [15:0] expected);
        host.send_frame({1'b1, `SE_CLS_READ, low, addr}, 16'h0000, 0, 19);
        check("read bits", {15'h0, host.read_bits[17:1]}, {16'h0, expected});
        check("oe cycles", 32'(host.oe_count), 32'h11);
        check("oe after read", 32'(host.oe_last), 32'h0);
        check("voltage in read", 32'(program_voltage), 32'h0);
        host.release_select(150);
    endtask : read_word

    function automatic logic [15:0] word_of(input int i);
        return 16'h1234 ^ (16'(i) * 16'h0F11);
    endfunction : word_of

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_word_cycle;
        check("enable at reset", 32'(program_enabled), 32'h0);
        program_op({1'b1, `SE_OPC_ENABLE, 4'h9}, 16'h0000, 0, 1'b0);
        check("enable latch", 32'(program_enabled), 32'h1);
        program_op({1'b1, `SE_CLS_ERASE, 2'h1, 4'h5}, 16'h0000, 0, 1'b1);
        read_word(4'h5, 2'h3, `SE_WORD_ERASED);
        program_op({1'b1, `SE_CLS_WRITE, 2'h2, 4'h5}, 16'hA5C3, 16, 1'b1);
        read_word(4'h5, 2'h0, 16'hA5C3);
        program_op({1'b1, `SE_OPC_DISABLE, 4'h6}, 16'h0000, 0, 1'b0);
        check("disable latch", 32'(program_enabled), 32'h0);
        program_op({1'b1, `SE_CLS_ERASE, 2'h0, 4'h5}, 16'h0000, 0, 1'b0);
        program_op({1'b1, `SE_CLS_WRITE, 2'h3, 4'h5}, 16'h0000, 16, 1'b0);
        read_word(4'h5, 2'h1, 16'hA5C3);
    endtask : t_word_cycle

    task automatic t_bulk;
        program_op({1'b1, `SE_OPC_ENABLE, 4'h0}, 16'h0000, 0, 1'b0);
        set_bulk(1'b0);
        program_op({1'b1, `SE_OPC_ERASE_ALL, 4'hF}, 16'h0000, 0, 1'b0);
        read_word(4'h5, 2'h2, 16'hA5C3);
        set_bulk(1'b1);
        program_op({1'b1, `SE_OPC_ERASE_ALL, 4'hA}, 16'h0000, 0, 1'b1);
        for (int i = 0; i < 16; i++) read_word(4'(i), 2'(i), `SE_WORD_ERASED);
        set_bulk(1'b0);
        program_op({1'b1, `SE_OPC_WRITE_ALL, 4'h3}, 16'h3C96, 16, 1'b0);
        read_word(4'h9, 2'h0, `SE_WORD_ERASED);
        set_bulk(1'b1);
        program_op({1'b1, `SE_OPC_WRITE_ALL, 4'hC}, 16'h3C96, 16, 1'b1);
        read_word(4'h0, 2'h1, 16'h3C96);
        read_word(4'hF, 2'h2, 16'h3C96);
    endtask : t_bulk

    // Mid-run reset: enable clears, array keeps its words, a cut read releases
    task automatic t_reset;
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        check("enable after reset", 32'(program_enabled), 32'h0);
        check("voltage after reset", 32'(program_voltage), 32'h0);
        read_word(4'h7, 2'h3, 16'h3C96);
        host.send_frame({1'b1, `SE_CLS_READ, 2'h0, 4'h2}, 16'h0000, 0, 6);
        check("oe cut read", 32'(host.oe_count), 32'h5);
        host.release_select(150);
        check("oe after cut read", 32'(serial_out_oe), 32'h0);
        program_op({1'b1, `SE_OPC_ENABLE, 4'h0}, 16'h0000, 0, 1'b0);
        check("enable after reset", 32'(program_enabled), 32'h1);
    endtask : t_reset

    task automatic t_addresses;
        program_op({1'b1, `SE_OPC_ERASE_ALL, 4'h5}, 16'h0000, 0, 1'b1);
        for (int i = 0; i < 16; i++) program_op({1'b1, `SE_CLS_WRITE, 2'(i), 4'(i)}, word_of(i), 16, 1'b1);
        for (int i = 0; i < 16; i++) read_word(4'(i), 2'(15 - i), word_of(i));
    endtask : t_addresses

    // ****************************************
    // Clock, sequence and watchdog
    // ****************************************
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    initial begin
        n_errors               = 0;
        check_count            = 0;
        rstn_in                = 1'b0;
        bulk_program_enable_in = 1'b1;
        repeat (6) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        t_word_cycle();
        t_bulk();
        t_reset();
        t_addresses();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge core_clk_in);
        n_errors++;
        $display("run exceeded its cycle limit");
        finish_test();
    end
endmodule : serial_eeprom_port_tb

`default_nettype wire

/* File: serial_eeprom_regs.svh */
// Constants for the 16x16 serial memory port: instruction fields, opcodes, timing.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef SERIAL_EEPROM_REGS_SVH
`define SERIAL_EEPROM_REGS_SVH

// ****************************************
// Instruction format
// ****************************************
`define SE_INSTR_BITS      9
`define SE_DATA_BITS       16
`define SE_WORDS           16
`define SE_ADDR_BITS       4
`define SE_OPC_MSB         7
`define SE_OPC_LSB         4
`define SE_ADDR_MSB        3
`define SE_ADDR_LSB        0

// ****************************************
// Opcodes, two-bit classes and four-bit specials
// ****************************************
`define SE_CLS_READ        2'h2
`define SE_CLS_WRITE       2'h1
`define SE_CLS_ERASE       2'h3
`define SE_OPC_ENABLE      4'h3
`define SE_OPC_DISABLE     4'h0
`define SE_OPC_ERASE_ALL   4'h2
`define SE_OPC_WRITE_ALL   4'h1

// ****************************************
// Erased word value, timing and FIFO depth
// ****************************************
`define SE_WORD_ERASED     16'hFFFF
`define SE_CLK_PERIOD_NS   10
`define SE_CS_LOW_MIN_NS   1000
`define SE_CS_LOW_MIN_CYC  ((`SE_CS_LOW_MIN_NS + `SE_CLK_PERIOD_NS - 1) / `SE_CLK_PERIOD_NS)
`define SE_FIFO_DEPTH      16

`endif

/* File: serial_host_model.sv */
// Host side of the three-wire serial memory link: frames, read capture, select timing.
// Assumes the core clock as time base; the serial clock runs at 80 ns only inside frames.
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    // Time base
    input  wire logic core_clk_in,
    // Link pins
    output logic      chip_select_out,
    output logic      serial_clock_out,
    output logic      host_data_out,
    input  wire logic serial_out_in,
    input  wire logic serial_out_oe_in
);
    // ****************************************
    // Capture state
    // ****************************************
    logic [17:0] read_bits;
    int          oe_count;
    logic        oe_last;

    initial begin
        chip_select_out  = 1'b0;
        serial_clock_out = 1'b0;
        host_data_out    = 1'b0;
        read_bits        = '0;
        oe_count         = 0;
        oe_last          = 1'b0;
    end

    // Samples just before the next rise, so slow output launch still counts
    task automatic shift_cycle(input logic b, input bit keep);
        @(posedge core_clk_in);
        serial_clock_out <= 1'b0;
        host_data_out    <= b;
        repeat (3) @(posedge core_clk_in);
        #1;
        oe_last = serial_out_oe_in;
        if (keep) begin
            // Released line shows the inverse, so an early release reads wrong
            read_bits = {read_bits[16:0], (serial_out_oe_in === 1'b1) ? serial_out_in : ~serial_out_in};
            if (serial_out_oe_in === 1'b1) begin
                oe_count++;
            end
        end
        @(posedge core_clk_in);
        serial_clock_out <= 1'b1;
        repeat (3) @(posedge core_clk_in);
    endtask : shift_cycle

    task automatic send_frame(input logic [8:0] instr, input logic [15:0] data, input int n_data,
                              input int n_extra);
        oe_count  = 0;
        read_bits = '0;
        @(posedge core_clk_in);
        chip_select_out <= 1'b1;
        shift_cycle(1'b0, 1'b1);
        for (int i = 8; i >= 0; i--) shift_cycle(instr[i], 1'b1);
        for (int i = 15; i >= 16 - n_data; i--) shift_cycle(data[i], 1'b1);
        for (int i = 0; i < n_extra; i++) shift_cycle(~host_data_out, i > 0);
    endtask : send_frame

    // Interval far below 10 ms to keep runs short; clock stands still meanwhile
    task automatic release_select(input int n_cycles);
        @(posedge core_clk_in);
        chip_select_out  <= 1'b0;
        serial_clock_out <= 1'b0;
        host_data_out    <= ~host_data_out;
        repeat (n_cycles) @(posedge core_clk_in);
    endtask : release_select
endmodule : serial_host_model

`default_nettype wire
